// >>> rtl/msl_pkg.sv
// Shared constants and types for the two-wire memory slave
package msl_pkg;
  // Memory geometry
  localparam int           MSL_AW        = 11;
  localparam int           MSL_DW        = 8;
  localparam int           MSL_WORDS     = 2048;
  localparam int           MSL_FIFO_DEP  = 16;
  localparam int           MSL_PUSH_W    = MSL_AW + MSL_DW;
  // Bit counter marks within one 9-clock frame
  localparam logic [3:0]   MSL_ACK_SLOT  = 4'h8;
  localparam logic [3:0]   MSL_FRAME_END = 4'h9;
  // Address word field positions
  localparam int           MSL_TYPE_MSB  = 7;
  localparam int           MSL_TYPE_LSB  = 4;
  localparam int           MSL_HI_MSB    = 3;
  localparam int           MSL_HI_LSB    = 1;
  localparam int           MSL_RW_BIT    = 0;
  localparam logic         MSL_RW_READ   = 1'b1;
  // Type code default is arbitrary, not any real part's code
  localparam logic [3:0]   MSL_TYPE_DEF  = 4'h5;
  // Reset values
  localparam logic [10:0]  MSL_ABUF_RST  = 11'h000;
  localparam logic [3:0]   MSL_CNT_RST   = 4'h0;

  // Protocol states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DEV  = 5'b00010,
    ST_LOW  = 5'b00100,
    ST_WR   = 5'b01000,
    ST_RD   = 5'b10000
  } msl_state_e;
endpackage

// >>> rtl/msl_stream_if.sv
// Valid/ready word stream between the slave's own modules
`timescale 1ns/1ps
interface msl_stream_if #(
  parameter int W = 19
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/msl_fifo.sv
// Write FIFO between the serial front end and the array
`timescale 1ns/1ps
module msl_fifo
  import msl_pkg::*;
#(
  parameter int W     = MSL_PUSH_W,
  parameter int DEPTH = MSL_FIFO_DEP
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rstn,
  // Streams
  msl_stream_if.snk   in_s,
  msl_stream_if.src   out_s
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Handshake decode
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;
  assign in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rp_q];

  // Storage, written at the write pointer
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= PW'(wp_q + 1'b1);
      if (pop)  rp_q <= PW'(rp_q + 1'b1);
      cnt_q <= (PW+1)'(cnt_q + push - pop);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_fifo_full_ready: assert property (
    (cnt_q == (PW+1)'(DEPTH)) |-> !in_s.ready)
    else $error("fifo full but still ready");
  chk_fifo_fill_step: assert property (
    (push && !pop) |=> (cnt_q == (PW+1)'($past(cnt_q) + 1'b1)))
    else $error("fifo level not raised by a push");
endmodule

// >>> rtl/msl_array.sv
// Byte array stored in flip-flops, one write and one read port
`timescale 1ns/1ps
module msl_array
  import msl_pkg::*;
#(
  parameter int AW = MSL_AW,
  parameter int DW = MSL_DW
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port, data one cycle after the strobe
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] cell_q [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      cell_q[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= cell_q[rd_addr];
    end
  end
endmodule

// >>> rtl/msl_slave.sv
// Two-wire serial slave front end for a 2048 x 8 byte memory
`timescale 1ns/1ps
module msl_slave
  import msl_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = MSL_TYPE_DEF,
  parameter int         FIFO_DEP  = MSL_FIFO_DEP
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Serial pins
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe,
  // Write lock pin
  input  wire logic          wlock_i,
  // Status
  output logic               busy_o,
  output logic [MSL_AW-1:0]  addr_o,
  output logic               wr_stb_o
);
  // Synchroniser stages and delayed samples
  logic              scl_m_q, scl_s_q, scl_p_q;
  logic              sda_m_q, sda_s_q, sda_p_q;
  logic              wl_m_q,  wl_s_q;
  // Protocol state
  msl_state_e        st_q, st_d;
  logic [3:0]        cnt_q;
  logic [7:0]        rx_q;
  logic [7:0]        tx_q;
  logic [2:0]        hi_q;
  logic              mack_q;
  logic              fresh_q;
  logic              oe_q;
  logic [MSL_AW-1:0] abuf_q;
  logic              push_v_q;
  logic [MSL_PUSH_W-1:0] push_d_q;
  // Array side
  logic              rd_stb;
  logic [MSL_AW-1:0] rd_addr;
  logic [7:0]        rd_data;

  msl_stream_if #(.W(MSL_PUSH_W)) push_if ();
  msl_stream_if #(.W(MSL_PUSH_W)) drain_if ();

  // Address of the next access: the stored one if not yet used
  function automatic logic [MSL_AW-1:0] next_access(
    input logic [MSL_AW-1:0] base,
    input logic              fresh);
    next_access = fresh ? base : MSL_AW'(base + 1'b1);
  endfunction

  // lock reads low out of reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {wl_m_q, wl_s_q}            <= 2'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      {wl_m_q, wl_s_q}            <= {wlock_i, wl_m_q};
    end
  end

  // Bus events from synchronised samples
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  // start is SDA fall with SCL high
  assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  // stop is SDA rise with SCL high
  assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // Frame decode
  logic active, byte_done, frame_end, type_ok, rw_rd;
  logic dev_hit, dev_miss, low_take, wr_take, wr_refuse;
  logic ack_drive, m_ack, rd_load, tx_fall;
  logic [2:0] rx_hi;
  logic [MSL_AW-1:0] dev_rd_addr, wr_addr;
  assign active    = (st_q != ST_IDLE);
  assign byte_done = active & scl_fall & (cnt_q == MSL_ACK_SLOT);
  assign frame_end = active & scl_fall & (cnt_q == MSL_FRAME_END);
  // middle bits are upper address only
  assign type_ok   = (rx_q[MSL_TYPE_MSB:MSL_TYPE_LSB] == TYPE_CODE);
  assign rx_hi     = rx_q[MSL_HI_MSB:MSL_HI_LSB];
  assign rw_rd     = (rx_q[MSL_RW_BIT] == MSL_RW_READ);
  assign dev_hit   = byte_done & (st_q == ST_DEV) & type_ok;
  assign dev_miss  = byte_done & (st_q == ST_DEV) & ~type_ok;
  assign low_take  = byte_done & (st_q == ST_LOW);
  // Write byte refused when the FIFO cannot take it
  assign wr_take   = byte_done & (st_q == ST_WR) & push_if.ready;
  assign wr_refuse = byte_done & (st_q == ST_WR) & ~push_if.ready;
  // ack address word, low byte and each data byte the FIFO takes
  assign ack_drive = dev_hit | low_take | wr_take;
  // master ack sampled on ninth rise
  assign m_ack     = scl_rise & (st_q == ST_RD) &
                     (cnt_q == MSL_ACK_SLOT) & ~sda_s_q;
  assign rd_load   = frame_end & (((st_q == ST_DEV) & rw_rd) |
                                  ((st_q == ST_RD) & mack_q));
  assign tx_fall   = scl_fall & (st_q == ST_RD) &
                     (cnt_q != MSL_CNT_RST) & (cnt_q < MSL_ACK_SLOT);
  // upper bits with buffered low byte
  assign dev_rd_addr = next_access({rx_hi, abuf_q[7:0]}, fresh_q);
  assign wr_addr   = next_access(abuf_q, fresh_q);

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: st_d = ST_IDLE;
      ST_DEV: begin
        if (dev_miss) begin
          st_d = ST_IDLE;
        end else if (frame_end) begin
          st_d = rw_rd ? ST_RD : ST_LOW;
        end
      end
      ST_LOW: begin
        if (frame_end) st_d = ST_WR;
      end
      ST_WR: begin
        if (wr_refuse) st_d = ST_IDLE;
      end
      ST_RD: begin
        // no master ack: release and wait
        if (frame_end && !mack_q) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // State register with start and stop overriding
  // start accepted straight after a stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
    end else if (start_ev) begin
      st_q <= ST_DEV;
    end else if (stop_ev) begin
      // stop ends read or write input
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Bit counter over the 9-clock frame
  always_ff @(posedge clk) begin
    if (!rstn || start_ev || stop_ev || frame_end) begin
      cnt_q <= MSL_CNT_RST;
    end else if (scl_rise && active) begin
      cnt_q <= 4'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_q   <= '0;
      mack_q <= 1'b0;
    end else if (scl_rise && active) begin
      if (cnt_q < MSL_ACK_SLOT) rx_q <= {rx_q[6:0], sda_s_q};
      if (cnt_q == MSL_ACK_SLOT) mack_q <= ~sda_s_q;
    end
  end

  // Transmit shift register, loaded at frame end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_q <= '0;
    end else if (rd_load) begin
      tx_q <= {rd_data[6:0], 1'b0};
    end else if (tx_fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // SDA drive changes only on SCL fall, start or stop
  // ack on ninth clock, release when sending
  // every byte framed by an ack slot
  always_ff @(posedge clk) begin
    if (!rstn || start_ev || stop_ev) begin
      oe_q <= 1'b0;
    end else if (ack_drive) begin
      oe_q <= 1'b1;
    end else if (rd_load) begin
      oe_q <= ~rd_data[7];
    end else if (tx_fall) begin
      oe_q <= ~tx_q[7];
    end else if (scl_fall && active) begin
      oe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      abuf_q  <= MSL_ABUF_RST;
      hi_q    <= '0;
      fresh_q <= 1'b0;
    end else if (dev_hit) begin
      hi_q <= rx_hi;
      if (rw_rd) begin
        abuf_q  <= dev_rd_addr;
        fresh_q <= 1'b0;
      end
    end else if (low_take) begin
      abuf_q  <= {hi_q, rx_q};
      fresh_q <= 1'b1;
    end else if (wr_take) begin
      abuf_q  <= wr_addr;
      fresh_q <= 1'b0;
    end else if (m_ack) begin
      abuf_q <= MSL_AW'(abuf_q + 1'b1);
    end
  end

  // locked bytes never enter the FIFO
  // locked bytes still acked, then dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      push_v_q <= 1'b0;
      push_d_q <= '0;
    end else begin
      push_v_q <= wr_take & ~wl_s_q;
      push_d_q <= {wr_addr, rx_q};
    end
  end

  // Array read strobe and address
  assign rd_stb  = (dev_hit & rw_rd) | m_ack;
  assign rd_addr = m_ack ? MSL_AW'(abuf_q + 1'b1) : dev_rd_addr;

  // Stream hookup; array writes stall while a read is issued
  assign push_if.valid  = push_v_q;
  assign push_if.data   = push_d_q;
  assign drain_if.ready = ~rd_stb;

  msl_fifo #(.W(MSL_PUSH_W), .DEPTH(FIFO_DEP)) u_fifo (
    .clk   (clk),
    .rstn  (rstn),
    .in_s  (push_if),
    .out_s (drain_if)
  );

  msl_array #(.AW(MSL_AW), .DW(MSL_DW)) u_array (
    .clk     (clk),
    .wr_en   (wr_stb_o),
    .wr_addr (drain_if.data[MSL_PUSH_W-1:MSL_DW]),
    .wr_data (drain_if.data[MSL_DW-1:0]),
    .rd_en   (rd_stb),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // Outputs
  // open drain: level always low
  assign sda_o    = 1'b0;
  assign sda_oe   = oe_q;
  assign busy_o   = active;
  assign addr_o   = abuf_q;
  assign wr_stb_o = drain_if.valid & drain_if.ready;

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_dev_hit;
    (st_q == ST_DEV) && scl_fall && (cnt_q == MSL_ACK_SLOT) && type_ok;
  endsequence
  sequence seq_rd_ack_rise;
    (st_q == ST_RD) && scl_rise && (cnt_q == MSL_ACK_SLOT) && !sda_s_q;
  endsequence

  chk_sda_change_fall: assert property (
    $changed(oe_q) |-> $past(scl_fall || start_ev || stop_ev))
    else $error("SDA drive changed away from SCL fall");
  chk_lock_no_push: assert property (
    push_v_q |-> !$past(wl_s_q))
    else $error("write pushed while locked");
  chk_start_to_dev: assert property (
    start_ev |=> (st_q == ST_DEV) && (cnt_q == MSL_CNT_RST) && !oe_q)
    else $error("start not taken");
  chk_stop_standby: assert property (
    stop_ev |=> (st_q == ST_IDLE) && !oe_q)
    else $error("stop did not end transfer");
  chk_dev_ack_slot: assert property (
    seq_dev_hit |=> oe_q [*8])
    else $error("address word not acked");
  chk_type_miss: assert property (
    ((st_q == ST_DEV) && byte_done && !type_ok) |=>
      (st_q == ST_IDLE) && !oe_q)
    else $error("mismatching type code answered");
  chk_seq_addr_step: assert property (
    seq_rd_ack_rise |=> abuf_q == MSL_AW'($past(abuf_q) + 1'b1))
    else $error("sequential read address not advanced");
  chk_tx_release: assert property (
    ((st_q == ST_RD) && byte_done) |=> !oe_q)
    else $error("read data not released on ninth clock");
  chk_nack_idle: assert property (
    ((st_q == ST_RD) && frame_end && !mack_q) |=>
      (st_q == ST_IDLE) && !oe_q)
    else $error("no master ack but still sending");
endmodule

// >>> tb/msl_master.sv
// Two-wire bus master model that drives the slave's serial pins
`timescale 1ns/1ps
module msl_master (
  // Clock
  input  wire logic clk,
  // Bus wire level and master drives
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int Q = 4; // Quarter bit, 80 ns per bit

  // Idle bus: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Wait a number of falling clock edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data moves only with clock low
  task automatic bit_io(input logic b, output logic s);
    tick(Q);
    sda_low = ~b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    s = sda;
    tick(Q);
    scl = 1'b0;
  endtask

  task automatic start();
    tick(Q);
    sda_low = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_low = 1'b1;
    tick(Q);
    scl = 1'b0;
  endtask

  // Data rises while clock high, bus left idle
  task automatic stop();
    tick(Q);
    sda_low = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_low = 1'b0;
    tick(Q);
  endtask

  // byte out, then release for the ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in with the line released
  task automatic recv(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module tb
  import msl_pkg::*;
;
  localparam logic [3:0] TC = MSL_TYPE_DEF;

  // Pins and bench state
  logic              clk;
  logic              rstn;
  logic              wlock_i;
  logic              scl;
  logic              mst_low;
  logic              sda_o;
  logic              sda_oe;
  logic              busy_o;
  logic [MSL_AW-1:0] addr_o;
  logic              wr_stb_o;
  wire logic         sda_w;
  logic              ack;
  logic [7:0]        rd;
  int                fail_count;
  int                samples_checked;
  int                wr_cnt;

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Open-drain wire with pull-up
  assign sda_w = mst_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  msl_slave #(
    .TYPE_CODE (TC),
    .FIFO_DEP  (MSL_FIFO_DEP)
  ) dut (
    .clk      (clk),
    .rstn     (rstn),
    .scl_i    (scl),
    .sda_i    (sda_w),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .wlock_i  (wlock_i),
    .busy_o   (busy_o),
    .addr_o   (addr_o),
    .wr_stb_o (wr_stb_o)
  );

  msl_master mst (
    .clk     (clk),
    .sda     (sda_w),
    .scl     (scl),
    .sda_low (mst_low)
  );

  // Compare a single bit
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  // Compare an address or data value
  task automatic chk_val(input string n, input logic [10:0] e,
                         input logic [10:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Count array writes, watch the open-drain output, away from the edge
  always @(negedge clk) begin
    if (wr_stb_o === 1'b1) wr_cnt++;
    if (sda_oe === 1'b1) chk_bit("sda_o", 1'b0, sda_o);
  end

  // write word and low address byte
  task automatic set_addr(input logic [10:0] a);
    mst.start();
    mst.send({TC, a[10:8], 1'b0}, ack);
    chk_bit("ack_word", 1'b1, ack);
    mst.send(a[7:0], ack);
    chk_bit("ack_low", 1'b1, ack);
  endtask

  // One data byte toward the array
  task automatic wr(input logic [7:0] d);
    mst.send(d, ack);
    chk_bit("ack_data", 1'b1, ack);
  endtask

  // Start and read-direction word
  task automatic rd_word(input logic [2:0] up);
    mst.start();
    mst.send({TC, up, 1'b1}, ack);
    chk_bit("ack_rd_word", 1'b1, ack);
  endtask

  // One byte from the device, then ack or nack
  task automatic rd_byte(input logic [7:0] e, input logic nack);
    logic s;
    mst.recv(rd);
    chk_val("rd_data", {3'h0, e}, {3'h0, rd});
    mst.bit_io(nack, s);
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    samples_checked = 0;
    wr_cnt = 0;
    rstn = 1'b0;
    wlock_i = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk_bit("busy_rst", 1'b0, busy_o);
    chk_val("addr_rst", MSL_ABUF_RST, addr_o);
    // Page write across the top, then a new start at once
    set_addr(11'h7ff);
    wr(8'ha5);
    wr(8'h3c);
    wr(8'h96);
    mst.stop();
    set_addr(11'h101);
    wr(8'hc7);
    mst.stop();
    repeat (4) @(negedge clk);
    chk_val("wr_count", 11'h004, wr_cnt[10:0]);
    chk_bit("busy_stop", 1'b0, busy_o);
    // Random read then sequential read through the wrap
    set_addr(11'h7ff);
    rd_word(3'h7);
    rd_byte(8'ha5, 1'b0);
    rd_byte(8'h3c, 1'b1);
    mst.stop();
    // Current read mixes word upper bits with buffered low byte
    rd_word(3'h1);
    rd_byte(8'hc7, 1'b1);
    repeat (8) @(negedge clk);
    chk_bit("oe_nack", 1'b0, sda_oe);
    chk_bit("busy_nack", 1'b0, busy_o);
    chk_val("addr_buf", 11'h101, addr_o);
    mst.stop();
    // Foreign type code gets no ack
    mst.start();
    mst.send({TC ^ 4'h1, 3'h0, 1'b0}, ack);
    chk_bit("ack_foreign", 1'b0, ack);
    repeat (8) @(negedge clk);
    chk_bit("busy_foreign", 1'b0, busy_o);
    mst.stop();
    // Locked write is acked but leaves the byte alone
    wlock_i = 1'b1;
    set_addr(11'h001);
    wr(8'h00);
    mst.stop();
    wlock_i = 1'b0;
    set_addr(11'h001);
    rd_word(3'h0);
    mst.recv(rd);
    chk_val("rd_locked", 11'h096, {3'h0, rd});
    mst.stop();
    repeat (8) @(negedge clk);
    chk_bit("busy_rdstop", 1'b0, busy_o);
    report_and_stop();
  end

  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule
